// *** hdl/qpit_top.sv ***
// Interrupt tree for four line ports: clear-on-read event status,
// per-port source pointers, a channel summary and one interrupt pin.
// Assumes event pulses on hclk and an asynchronous PLL lock level.
//
// Functional notes
// - One interrupt pin; its output type comes from a two-bit pin field.
// - Reading an event status register clears what it returned.
// - A set mask bit blocks the interrupt and, normally, the recording.
// - Each port has a source pointer flagging status registers with work.
// - Channel summary bit n+1 is set while port n has pointer bits set; bit 0 reads zero.
// - Pointer bit follows its status register after each read.
// - Summary clears with its pointer; the pin drops a cycle later unless another summary bit is set or an unmasked PLL change is pending.
// - Status updates during a read are applied after it, never lost.
// - Visible mode records masked events without raising the pin.
// - PLL lock status is an interrupt source with its own mask.
// - PLL visible mode shows masked lock changes without interrupting.
// - In visible mode a read clears masked and unmasked bits alike.
`timescale 1ns/1ps
module qpit_top
    import qpit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] port_event,
    input wire logic pll_locked,
    output logic irq_out,
    output logic irq_oe_n
);
    // ==========================================================
    // Bus phases
    logic rd_take;
    logic wr_take;
    logic [QPIT_AW-1:0] raddr;
    qpit_wacc_t wacc_reg;
    qpit_wacc_t wacc_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic [7:0] wbyte;

    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    assign raddr = haddr[QPIT_AW-1:0];
    assign wbyte = hwdata[7:0];
    // Writes land in the data phase, reads are answered from a flop.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_comb
    begin
        wacc_next.valid = wr_take;
        wacc_next.addr = wr_take ? raddr : wacc_reg.addr;
    end

    function automatic logic [11:0] reg_off(input logic [11:0] base,
                                            input int p, input int r);
        reg_off = base + 12'(p) * QPIT_PORT_STRIDE + 12'(r) * QPIT_REG_STRIDE;
    endfunction

    function automatic logic wr_hit(input qpit_wacc_t a,
                                    input logic [11:0] off);
        wr_hit = a.valid && (a.addr == off);
    endfunction

    // ==========================================================
    // Configuration registers
    logic [QPIT_NPORT-1:0] vis_reg;
    logic [QPIT_NPORT-1:0] vis_next;
    logic pll_mask_reg;
    logic pll_mask_next;
    qpit_pincfg_t pincfg_reg;
    qpit_pincfg_t pincfg_next;

    always_comb
    begin
        vis_next = vis_reg;
        for (int p = 0; p < QPIT_NPORT; p++)
        begin
            if (wr_hit(wacc_reg, reg_off(QPIT_GCTRL_BASE, 0, p)))
            begin
                vis_next[p] = wbyte[QPIT_VIS_BIT];
            end
        end
        pll_mask_next = wr_hit(wacc_reg, QPIT_PLLMASK_OFF) ? wbyte[0]
                                                           : pll_mask_reg;
        pincfg_next = pincfg_reg;
        if (wr_hit(wacc_reg, QPIT_PINCFG_OFF))
        begin
            pincfg_next.output_type_sel = wbyte[1:0];
            pincfg_next.pll_visible_mode = wbyte[QPIT_PLL_VIS_BIT];
        end
    end

    // ==========================================================
    // Per-port status, mask and source pointer
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] stat_reg;
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] stat_next;
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] mask_reg;
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] mask_next;
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0] port_source_pointer;
    logic [QPIT_NPORT:0] channel_summary;

    genvar gp, gr;
    generate
        for (gp = 0; gp < QPIT_NPORT; gp++)
        begin : g_port
            for (gr = 0; gr < QPIT_NREG; gr++)
            begin : g_reg
                logic rd_clr;
                logic [7:0] w1c;
                logic [7:0] accept;
                assign rd_clr = rd_take
                    && raddr == reg_off(QPIT_STAT_BASE, gp, gr);
                assign w1c = wr_hit(wacc_reg,
                    reg_off(QPIT_STAT_BASE, gp, gr)) ? wbyte : 8'h00;
                // Masked events are kept only in visible mode.
                assign accept = ~mask_reg[gp][gr]
                    | {8{vis_reg[gp]}};

                always_comb
                begin
                    // Read value is captured from the old contents while
                    // the clear and any new event apply together; the
                    // event wins, so nothing arriving mid-read is lost.
                    stat_next[gp][gr] = (stat_reg[gp][gr]
                        & ~(rd_clr ? 8'hff : 8'h00) & ~w1c)
                        | (port_event[gp][gr] & accept);
                    mask_next[gp][gr] = wr_hit(wacc_reg,
                        reg_off(QPIT_MASK_BASE, gp, gr)) ? wbyte
                        : mask_reg[gp][gr];
                end

                // Only unmasked bits point at work to do.
                assign port_source_pointer[gp][gr] =
                    |(stat_reg[gp][gr] & ~mask_reg[gp][gr]);
            end
            assign channel_summary[gp+1] = |port_source_pointer[gp];
        end
    endgenerate
    assign channel_summary[0] = 1'b0;

    // ==========================================================
    // PLL lock source
    logic pll_s1_reg;
    logic pll_s2_reg;
    logic pll_s3_reg;
    logic pll_lock_state_reg;
    logic pll_lock_state_next;
    logic pll_lock_change_reg;
    logic pll_lock_change_next;
    logic pll_evt;
    logic pll_rd_clr;
    logic pll_w1c;

    // A lock change counts once the second and third stages agree.
    assign pll_evt = (pll_s2_reg == pll_s3_reg)
        && (pll_s3_reg != pll_lock_state_reg);
    assign pll_rd_clr = rd_take && raddr == QPIT_PLLSTAT_OFF;
    assign pll_w1c = wr_hit(wacc_reg, QPIT_PLLSTAT_OFF)
        && wbyte[QPIT_PLL_CHANGE_BIT];

    always_comb
    begin
        pll_lock_state_next = pll_evt ? pll_s3_reg : pll_lock_state_reg;
        pll_lock_change_next = (pll_lock_change_reg
            && !pll_rd_clr && !pll_w1c)
            || (pll_evt && (!pll_mask_reg
            || pincfg_reg.pll_visible_mode));
    end

    // ==========================================================
    // Interrupt pin
    logic irq_reg;
    logic irq_next;
    logic pll_irq;

    assign pll_irq = pll_lock_change_reg && !pll_mask_reg;
    // Registered so the pin never glitches while bits settle.
    assign irq_next = (|channel_summary) || pll_irq;

    always_comb
    begin
        unique case (pincfg_reg.output_type_sel)
            QPIT_OT_PP_LOW:
            begin
                irq_out = !irq_reg;
                irq_oe_n = 1'b0;
            end
            QPIT_OT_PP_HIGH:
            begin
                irq_out = irq_reg;
                irq_oe_n = 1'b0;
            end
            default:
            begin
                irq_out = 1'b0;
                irq_oe_n = !irq_reg;
            end
        endcase
    end

    // ==========================================================
    // Read data
    always_comb
    begin
        hrdata_next = hrdata_reg;
        if (rd_take)
        begin
            hrdata_next = 32'h0000_0000;
            for (int p = 0; p < QPIT_NPORT; p++)
            begin
                for (int r = 0; r < QPIT_NREG; r++)
                begin
                    if (raddr == reg_off(QPIT_STAT_BASE, p, r))
                    begin
                        hrdata_next[7:0] = stat_reg[p][r];
                    end
                    if (raddr == reg_off(QPIT_MASK_BASE, p, r))
                    begin
                        hrdata_next[7:0] = mask_reg[p][r];
                    end
                end
                if (raddr == reg_off(QPIT_SRCPTR_BASE, 0, p))
                begin
                    hrdata_next[7:0] = port_source_pointer[p];
                end
                if (raddr == reg_off(QPIT_GCTRL_BASE, 0, p))
                begin
                    hrdata_next[QPIT_VIS_BIT] = vis_reg[p];
                end
            end
            unique case (raddr)
                QPIT_CHSUM_OFF:
                begin
                    hrdata_next[QPIT_NPORT:0] = channel_summary;
                end
                QPIT_PLLSTAT_OFF:
                begin
                    hrdata_next[QPIT_PLL_STATE_BIT] = pll_lock_state_reg;
                    hrdata_next[QPIT_PLL_CHANGE_BIT] = pll_lock_change_reg;
                end
                QPIT_PLLMASK_OFF:
                begin
                    hrdata_next[0] = pll_mask_reg;
                end
                QPIT_PINCFG_OFF:
                begin
                    hrdata_next[1:0] = pincfg_reg.output_type_sel;
                    hrdata_next[QPIT_PLL_VIS_BIT] =
                        pincfg_reg.pll_visible_mode;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wacc_reg <= '0;
            hrdata_reg <= 32'h0000_0000;
            vis_reg <= '0;
            pll_mask_reg <= QPIT_PLLMASK_RST;
            pincfg_reg <= '{pll_visible_mode: 1'b0,
                            output_type_sel: QPIT_OTYPE_RST};
            stat_reg <= {(QPIT_NPORT*QPIT_NREG){QPIT_STAT_RST}};
            mask_reg <= {(QPIT_NPORT*QPIT_NREG){QPIT_MASK_RST}};
            pll_s1_reg <= 1'b0;
            pll_s2_reg <= 1'b0;
            pll_s3_reg <= 1'b0;
            pll_lock_state_reg <= 1'b0;
            pll_lock_change_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            wacc_reg <= wacc_next;
            hrdata_reg <= hrdata_next;
            vis_reg <= vis_next;
            pll_mask_reg <= pll_mask_next;
            pincfg_reg <= pincfg_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            pll_s1_reg <= pll_locked;
            pll_s2_reg <= pll_s1_reg;
            pll_s3_reg <= pll_s2_reg;
            pll_lock_state_reg <= pll_lock_state_next;
            pll_lock_change_reg <= pll_lock_change_next;
            irq_reg <= irq_next;
        end
    end
endmodule

// *** pkg/qpit_pkg.sv ***
// Shared constants and carriers of the four-port interrupt tree.
// Assumes a 32-bit AHB-Lite slave port with 12 decoded address bits.
package qpit_pkg;
    // ==========================================================
    // Sizes
    localparam int QPIT_NPORT = 4;
    localparam int QPIT_NREG = 8;
    localparam int QPIT_AW = 12;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] QPIT_STAT_BASE = 12'h000;
    localparam logic [11:0] QPIT_MASK_BASE = 12'h100;
    localparam logic [11:0] QPIT_PORT_STRIDE = 12'h020;
    localparam logic [11:0] QPIT_REG_STRIDE = 12'h004;
    localparam logic [11:0] QPIT_SRCPTR_BASE = 12'h200;
    localparam logic [11:0] QPIT_GCTRL_BASE = 12'h210;
    localparam logic [11:0] QPIT_CHSUM_OFF = 12'h220;
    localparam logic [11:0] QPIT_PLLSTAT_OFF = 12'h224;
    localparam logic [11:0] QPIT_PLLMASK_OFF = 12'h228;
    localparam logic [11:0] QPIT_PINCFG_OFF = 12'h22c;
    // ==========================================================
    // Field positions
    localparam int QPIT_PLL_STATE_BIT = 0;
    localparam int QPIT_PLL_CHANGE_BIT = 1;
    localparam int QPIT_VIS_BIT = 0;
    localparam int QPIT_PLL_VIS_BIT = 2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] QPIT_MASK_RST = 8'hff;
    localparam logic [7:0] QPIT_STAT_RST = 8'h00;
    localparam logic [1:0] QPIT_OTYPE_RST = 2'h0;
    localparam logic QPIT_PLLMASK_RST = 1'b1;
    // ==========================================================
    // Output type encodings
    localparam logic [1:0] QPIT_OT_OD_LOW = 2'h0;
    localparam logic [1:0] QPIT_OT_PP_LOW = 2'h1;
    localparam logic [1:0] QPIT_OT_PP_HIGH = 2'h2;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [QPIT_AW-1:0] addr;
    } qpit_wacc_t;

    typedef struct packed {
        logic pll_visible_mode;
        logic [1:0] output_type_sel;
    } qpit_pincfg_t;
endpackage

// *** verification/qpit_asserts.sv ***
// Port checker for the four-port interrupt tree.
// Assumes it is bound onto qpit_top and sees only its ports.
`timescale 1ns/1ps
module qpit_asserts
    import qpit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq_out,
    input wire logic irq_oe_n
);
    // ==========
    // Helpers
    logic acc;
    logic rd;
    assign acc = hsel && htrans[1] && hready;
    assign rd = acc && !hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence rd_at(logic [11:0] a);
        rd && haddr[11:0] == a;
    endsequence
    sequence rd_gap;
        rd && haddr[11:0] >= 12'h230;
    endsequence
    // ==========
    // Properties
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus stalled or not okay");
    od_idle_a: assert property (irq_oe_n |-> !irq_out)
        else $error("released pin still driven high");
    rd_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    rd_hold_a: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    gap_zero_a: assert property (rd_gap |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chsum_bits_a: assert property (
        rd_at(QPIT_CHSUM_OFF) |=> hrdata[0] == 1'b0)
        else $error("summary bit zero set");
    vis_bits_a: assert property (
        rd && haddr[11:4] == 8'h21 |=> hrdata[7:1] == 7'h0)
        else $error("port control spare bits set");
    pin_release_a: assert property ($rose(irq_oe_n) |->
        $past(acc) || $past(acc, 2) || $past(acc, 3))
        else $error("pin released with no access");
endmodule
bind qpit_top qpit_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

// *** verification/qpit_host_pin.sv ***
// Host end of the interrupt pin: a pulled-up wire.
// Assumes the pin is split into a value and an active-low enable.
`timescale 1ns/1ps
module qpit_host_pin
(
    input wire logic irq_out,
    input wire logic irq_oe_n,
    output logic pin_level
);
    // The pull-up wins whenever the device lets go of the wire.
    assign pin_level = irq_oe_n ? 1'b1 : irq_out;
endmodule

// *** verification/quad_port_interrupt_tree_bench.sv ***
// Self-checking bench for the interrupt tree.
// Assumes qpit_top, its checker and the host pin model.
`timescale 1ns/1ps
module quad_port_interrupt_tree_bench;
    import qpit_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq_out, irq_oe_n, pin_level;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [QPIT_NPORT-1:0][QPIT_NREG-1:0][7:0] port_event = '0;
    logic pll_locked = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    always #50 hclk = ~hclk;
    qpit_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .port_event(port_event),
        .pll_locked(pll_locked), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
    qpit_host_pin i_host (.irq_out(irq_out), .irq_oe_n(irq_oe_n),
        .pin_level(pin_level));
    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Entered just after a rising edge; returns at the data-phase edge.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic pin_is(input logic v);
        check({31'h0, pin_level}, {31'h0, v});
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        rdc(QPIT_MASK_BASE, 32'hff);
        rdc(QPIT_STAT_BASE, 32'h0);
        rdc(QPIT_PLLMASK_OFF, 32'h1);
        rdc(12'h300, 32'h0);
        pin_is(1'b1);
        $display("test reset done");
    endtask
    task automatic t_mask;
        wr(12'h128, 32'hfe);
        port_event[1][2] <= 8'h03;
        @(posedge hclk);
        port_event <= '0;
        idle(2);
        pin_is(1'b0);
        rdc(QPIT_CHSUM_OFF, 32'h04);
        rdc(12'h204, 32'h04);
        rdc(12'h028, 32'h01);
        rdc(12'h028, 32'h0);
        rdc(12'h204, 32'h0);
        rdc(QPIT_CHSUM_OFF, 32'h0);
        idle(2);
        pin_is(1'b1);
        $display("test mask done");
    endtask
    task automatic t_visible;
        wr(QPIT_GCTRL_BASE, 32'h1);
        wr(QPIT_MASK_BASE, 32'hfe);
        rdc(QPIT_GCTRL_BASE, 32'h1);
        port_event[0][0] <= 8'h81;
        @(posedge hclk);
        port_event <= '0;
        idle(2);
        pin_is(1'b0);
        rdc(QPIT_SRCPTR_BASE, 32'h01);
        rdc(QPIT_STAT_BASE, 32'h81);
        rdc(QPIT_STAT_BASE, 32'h0);
        // A masked-only event is recorded but must not raise the pin.
        port_event[0][0] <= 8'h80;
        @(posedge hclk);
        port_event <= '0;
        idle(2);
        pin_is(1'b1);
        rdc(QPIT_SRCPTR_BASE, 32'h0);
        rdc(QPIT_STAT_BASE, 32'h80);
        wr(QPIT_GCTRL_BASE, 32'h0);
        $display("test visible done");
    endtask
    task automatic t_collide;
        wr(12'h15c, 32'h0);
        port_event[2][7] <= 8'h01;
        @(posedge hclk);
        port_event <= '0;
        idle(2);
        for (int t = 0; t < 4; t++)
        begin
            wr(QPIT_PINCFG_OFF, 32'(t));
            idle(1);
            pin_is(t == 2);
        end
        wr(QPIT_PINCFG_OFF, 32'h0);
        // The event lands on the same edge as the clearing read.
        fork
            xfer(1'b0, 12'h05c, 32'h0);
            begin
                port_event[2][7] <= 8'h01;
                @(posedge hclk);
                port_event <= '0;
            end
        join
        check(rd, 32'h01);
        rdc(12'h05c, 32'h01);
        rdc(12'h05c, 32'h0);
        $display("test collide done");
    endtask
    task automatic t_pll;
        // Masked and not visible: the lock change is dropped.
        pll_locked <= 1'b1;
        idle(8);
        pin_is(1'b1);
        rdc(QPIT_PLLSTAT_OFF, 32'h1);
        wr(QPIT_PINCFG_OFF, 32'h4);
        pll_locked <= 1'b0;
        idle(8);
        pin_is(1'b1);
        rdc(QPIT_PLLSTAT_OFF, 32'h2);
        wr(QPIT_PLLMASK_OFF, 32'h0);
        pll_locked <= 1'b1;
        idle(8);
        pin_is(1'b0);
        rdc(QPIT_PLLSTAT_OFF, 32'h3);
        idle(3);
        pin_is(1'b1);
        $display("test pll done");
    endtask
    // ==========
    // Run control
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_mask;
        t_visible;
        t_collide;
        t_pll;
        print_verdict;
    end
endmodule
